/* File: rtl/pbr_recovery_top.sv */
// Power-button and power-failure recovery sequencer with AXI4-Lite registers
`timescale 1ns/10ps
`include "pbr_cfg.svh"
module pbr_recovery_top
#(
   parameter int unsigned PULSE_CYCLES =
      (`PBR_PULSE_TIME_MS * `PBR_NS_PER_MS) / `PBR_CLK_PERIOD_NS
)
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Pins toward the front panel and chipset
   input  wire logic        powerButtonInputN,
   input  wire logic        sleepStateN,
   input  wire logic        keyboardPowerRequestN,
   output logic             powerButtonOutputN,
   output logic             supplyOnN,
   // Standby-retained storage, caught once after reset release
   input  wire logic [1:0]  retainedPolicy,
   input  wire logic        retainedSupplyOn,
   output logic [1:0]       keptPolicy,
   output logic             keptSupplyOn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   localparam int unsigned PulseLast = PULSE_CYCLES - 1;

   pbr_sync_if syncBus ();

   // Pin synchroniser
   pbr_input_sync u_sync
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .rawInN  ({sleepStateN, powerButtonInputN}),
      .syncOut (syncBus.src)
   );

   pbr_pkg::pbr_state_type  state_q, state_d;         // Recovery sequencer
   logic [31:0]             pulseCnt_q, pulseCnt_d;   // Pulse length counter
   pbr_pkg::pbr_policy_type policy_q, policy_d;       // Recovery policy
   logic                    btnEn_q, btnEn_d;         // Button pass-through enable
   logic                    kept_q, kept_d;           // Recorded supply state
   logic                    pbOutN_q, pbOutN_d;       // Power-button output
   logic                    supOnN_q, supOnN_d;       // Supply-on output
   logic                    wantOn;                   // Policy asks for supply on
   logic                    wrFire;                   // Register write this cycle

   // AXI4-Lite slave state
   logic        awHave_q, awHave_d;   // Write address held
   logic        wHave_q, wHave_d;     // Write data held
   logic [7:0]  awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0]  wStrb_q, wStrb_d;
   logic        bValid_q, bValid_d;
   logic [1:0]  bResp_q, bResp_d;
   logic        rValid_q, rValid_d;
   logic [1:0]  rResp_q, rResp_d;
   logic [31:0] rData_q, rData_d;
   logic        arReady_q, arReady_d;
   logic        awReady_q, awReady_d;
   logic        wReady_q, wReady_d;

   // Policy decode; the retained copy is used since registers just left reset
   always_comb
   begin
      unique case (pbr_pkg::pbr_policy_type'(retainedPolicy))
         pbr_pkg::PBR_POL_ON:   wantOn = 1'b1;
         pbr_pkg::PBR_POL_PREV: wantOn = retainedSupplyOn;
         pbr_pkg::PBR_POL_OFF,
         pbr_pkg::PBR_POL_OFF2: wantOn = 1'b0;
      endcase
   end

   // Sequencer next state: decide once after standby reset, then run
   always_comb
   begin
      state_d    = state_q;
      pulseCnt_d = pulseCnt_q;
      unique case (state_q)
         pbr_pkg::START_S:
         begin
            // Off policy skips the pulse and leaves the output alone
            pulseCnt_d = 32'h0000_0000;
            state_d    = wantOn ? pbr_pkg::PULSE_S : pbr_pkg::RUN_S;
         end
         pbr_pkg::PULSE_S:
         begin
            // Fixed length well inside the override limit
            if (pulseCnt_q >= PulseLast)
            begin
               state_d = pbr_pkg::RUN_S;
            end
            else
            begin
               pulseCnt_d = pulseCnt_q + 32'h0000_0001;
            end
         end
         pbr_pkg::RUN_S:
         begin
            state_d = pbr_pkg::RUN_S;
         end
      endcase
   end

   // Output and record next values
   always_comb
   begin
      // The pulse, the keyboard request or the button while enabled pulls the output low
      pbOutN_d = !((state_q == pbr_pkg::PULSE_S)
                   || (btnEn_q && !syncBus.buttonInN)
                   || !keyboardPowerRequestN);
      supOnN_d = !syncBus.sleepN;
      // Track the live supply state; seed from storage at start
      if (state_q == pbr_pkg::START_S)
      begin
         kept_d = retainedSupplyOn;
      end
      else
      begin
         kept_d = !supOnN_q;
      end
   end

   // Control register: policy field seeded from storage, then written by software
   always_comb
   begin
      policy_d = policy_q;
      btnEn_d  = btnEn_q;
      if (state_q == pbr_pkg::START_S)
      begin
         policy_d = pbr_pkg::pbr_policy_type'(retainedPolicy);
      end
      else if (wrFire && (awAddr_q == `PBR_CTRL_OFFSET) && wStrb_q[0])
      begin
         policy_d = pbr_pkg::pbr_policy_type'(
            wData_q[`PBR_CTRL_POLICY_MSB:`PBR_CTRL_POLICY_LSB]);
         btnEn_d  = wData_q[`PBR_CTRL_BTN_EN_BIT];
      end
   end

   // Register the block state
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q    <= pbr_pkg::START_S;
         pulseCnt_q <= 32'h0000_0000;
         policy_q   <= pbr_pkg::PBR_POL_OFF;
         btnEn_q    <= 1'b1;
         kept_q     <= 1'b0;
         pbOutN_q   <= 1'b1;
         supOnN_q   <= 1'b1;
      end
      else
      begin
         state_q    <= state_d;
         pulseCnt_q <= pulseCnt_d;
         policy_q   <= policy_d;
         btnEn_q    <= btnEn_d;
         kept_q     <= kept_d;
         pbOutN_q   <= pbOutN_d;
         supOnN_q   <= supOnN_d;
      end
   end

   assign powerButtonOutputN = pbOutN_q;
   assign supplyOnN          = supOnN_q;
   assign keptPolicy         = policy_q;
   assign keptSupplyOn       = kept_q;

   assign wrFire = awHave_q && wHave_q && !bValid_q;

   // Bus next values; address and data are taken in either order
   always_comb
   begin
      awHave_d = awHave_q;
      wHave_d  = wHave_q;
      awAddr_d = awAddr_q;
      wData_d  = wData_q;
      wStrb_d  = wStrb_q;
      bValid_d = bValid_q;
      bResp_d  = bResp_q;
      rValid_d = rValid_q;
      rResp_d  = rResp_q;
      rData_d  = rData_q;
      if (s_axi_awvalid && awReady_q)
      begin
         awHave_d = 1'b1;
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wReady_q)
      begin
         wHave_d = 1'b1;
         wData_d = s_axi_wdata;
         wStrb_d = s_axi_wstrb;
      end
      // Response once both halves are in; unmapped offsets answer SLVERR
      if (wrFire)
      begin
         awHave_d = 1'b0;
         wHave_d  = 1'b0;
         bValid_d = 1'b1;
         bResp_d  = ((awAddr_q == `PBR_CTRL_OFFSET) || (awAddr_q == `PBR_STAT_OFFSET))
                    ? `PBR_RESP_OKAY : `PBR_RESP_SLVERR;
      end
      else if (bValid_q && s_axi_bready)
      begin
         bValid_d = 1'b0;
      end
      // Reads answer one cycle after the address is taken
      if (s_axi_arvalid && arReady_q)
      begin
         rValid_d = 1'b1;
         rResp_d  = `PBR_RESP_OKAY;
         rData_d  = 32'h0000_0000;
         if (s_axi_araddr == `PBR_CTRL_OFFSET)
         begin
            rData_d[`PBR_CTRL_POLICY_MSB:`PBR_CTRL_POLICY_LSB] = policy_q;
            rData_d[`PBR_CTRL_BTN_EN_BIT]                      = btnEn_q;
         end
         else if (s_axi_araddr == `PBR_STAT_OFFSET)
         begin
            rData_d[`PBR_STAT_KEPT_BIT]  = kept_q;
            rData_d[`PBR_STAT_PULSE_BIT] = (state_q == pbr_pkg::PULSE_S);
            rData_d[`PBR_STAT_PBOUT_BIT] = pbOutN_q;
            rData_d[`PBR_STAT_SLEEP_BIT] = syncBus.sleepN;
         end
         else
         begin
            rResp_d = `PBR_RESP_SLVERR;
         end
      end
      else if (rValid_q && s_axi_rready)
      begin
         rValid_d = 1'b0;
      end
      // Ready drops as soon as an item is held, so one write is in flight
      awReady_d = !awHave_d && !bValid_d;
      wReady_d  = !wHave_d && !bValid_d;
      arReady_d = !rValid_d && !(s_axi_arvalid && arReady_q);
   end

   // Register the bus state
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         awHave_q  <= 1'b0;
         wHave_q   <= 1'b0;
         awAddr_q  <= 8'h00;
         wData_q   <= 32'h0000_0000;
         wStrb_q   <= 4'h0;
         bValid_q  <= 1'b0;
         bResp_q   <= `PBR_RESP_OKAY;
         rValid_q  <= 1'b0;
         rResp_q   <= `PBR_RESP_OKAY;
         rData_q   <= 32'h0000_0000;
         awReady_q <= 1'b0;
         wReady_q  <= 1'b0;
         arReady_q <= 1'b0;
      end
      else
      begin
         awHave_q  <= awHave_d;
         wHave_q   <= wHave_d;
         awAddr_q  <= awAddr_d;
         wData_q   <= wData_d;
         wStrb_q   <= wStrb_d;
         bValid_q  <= bValid_d;
         bResp_q   <= bResp_d;
         rValid_q  <= rValid_d;
         rResp_q   <= rResp_d;
         rData_q   <= rData_d;
         awReady_q <= awReady_d;
         wReady_q  <= wReady_d;
         arReady_q <= arReady_d;
      end
   end

   assign s_axi_awready = awReady_q;
   assign s_axi_wready  = wReady_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_bresp   = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid  = rValid_q;
   assign s_axi_rresp   = rResp_q;
   assign s_axi_rdata   = rData_q;

   // Helper: length of the current low pulse from the sequencer
   logic [31:0] pulseLen_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst || (state_q != pbr_pkg::PULSE_S))
      begin
         pulseLen_q <= 32'h0000_0000;
      end
      else
      begin
         pulseLen_q <= pulseLen_q + 32'h0000_0001;
      end
   end

   // Reset seen at the last edge; the state still shows reset values one
   // sample after release, so checks wait that one extra cycle
   logic rstLate_q;
   always_ff @(posedge clk)
   begin
      rstLate_q <= sys_rst;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst || rstLate_q);

   a_pulse_drives_low: assert property (
      state_q == pbr_pkg::PULSE_S |=> !powerButtonOutputN)
      else $error("recovery pulse not driven low");
   a_off_no_pulse: assert property (
      (state_q == pbr_pkg::START_S) && !wantOn
      |=> state_q == pbr_pkg::RUN_S ##1 state_q == pbr_pkg::RUN_S)
      else $error("off policy started a pulse");
   a_policy_on_pulse: assert property (
      (state_q == pbr_pkg::START_S) && (retainedPolicy == 2'h1)
      |=> state_q == pbr_pkg::PULSE_S)
      else $error("on policy gave no pulse");
   a_button_holds_low: assert property (
      btnEn_q && !syncBus.buttonInN |=> !powerButtonOutputN)
      else $error("button low not passed on");
   a_kbd_holds_low: assert property (
      !keyboardPowerRequestN |=> !powerButtonOutputN)
      else $error("keyboard request not passed on");
   a_pulse_length: assert property (
      $fell(state_q == pbr_pkg::PULSE_S) |-> $past(pulseLen_q) == PulseLast)
      else $error("recovery pulse length wrong");
   // The helper runs one past the end on the exit edge, so bound it inside the pulse
   a_pulse_bounded: assert property (
      (state_q == pbr_pkg::PULSE_S) |-> pulseLen_q < PULSE_CYCLES)
      else $error("recovery pulse too long");
   // The first sample after release still holds the reset value of the output
   a_supply_inverse: assert property (
      !$past(sys_rst) |-> supplyOnN == !$past(syncBus.sleepN))
      else $error("supply output not inverse of sleep");
   a_state_recorded: assert property (
      state_q == pbr_pkg::RUN_S ##1 state_q == pbr_pkg::RUN_S
      |-> keptSupplyOn == !$past(supplyOnN))
      else $error("supply state not recorded");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");

   c_recovery_pulse: cover property ($fell(state_q == pbr_pkg::PULSE_S));
   c_button_press: cover property (btnEn_q && !syncBus.buttonInN ##1 !powerButtonOutputN);
   c_keyboard_req: cover property (!keyboardPowerRequestN ##1 !powerButtonOutputN);
   c_ctrl_write: cover property (wrFire && (awAddr_q == `PBR_CTRL_OFFSET));

endmodule : pbr_recovery_top

/* File: rtl/pbr_cfg.svh */
// Offsets, field positions, reset values and timing counts of the power recovery block
`ifndef PBR_CFG_SVH
`define PBR_CFG_SVH

// Register byte offsets on the AXI4-Lite bus
`define PBR_CTRL_OFFSET      8'h00
`define PBR_STAT_OFFSET      8'h04

// Control register fields
`define PBR_CTRL_POLICY_LSB  0
`define PBR_CTRL_POLICY_MSB  1
`define PBR_CTRL_BTN_EN_BIT  2
`define PBR_CTRL_RESET       32'h0000_0004

// Status register fields
`define PBR_STAT_KEPT_BIT    0
`define PBR_STAT_PULSE_BIT   1
`define PBR_STAT_PBOUT_BIT   2
`define PBR_STAT_SLEEP_BIT   3

// AXI responses
`define PBR_RESP_OKAY        2'h0
`define PBR_RESP_SLVERR      2'h2

// Clock period and recovery pulse timing
`define PBR_CLK_PERIOD_NS    10
`define PBR_PULSE_TIME_MS    1000
`define PBR_PULSE_MIN_MS     500
`define PBR_PULSE_MAX_MS     4000
`define PBR_NS_PER_MS        1000000

// Synchroniser level after reset: button released, chipset asleep, so the
// supply-on output does not blip on while the stages fill after power-up
`define PBR_SYNC_RESET       2'h1

`endif

/* File: rtl/pbr_pkg.sv */
// Types shared by the power recovery block
package pbr_pkg;

   // Recovery policy codes as held in the control register
   typedef enum logic [1:0]
   {
      PBR_POL_OFF  = 2'h0,
      PBR_POL_ON   = 2'h1,
      PBR_POL_PREV = 2'h2,
      PBR_POL_OFF2 = 2'h3
   } pbr_policy_type;

   // Recovery sequencer states
   typedef enum logic [1:0]
   {
      START_S,
      PULSE_S,
      RUN_S
   } pbr_state_type;

endpackage : pbr_pkg

/* File: rtl/pbr_sync_if.sv */
// Interface carrying synchronised pin levels into the recovery logic
`timescale 1ns/10ps
interface pbr_sync_if;
   logic buttonInN;   // Filtered button level, active low
   logic sleepN;      // Filtered sleep state level, active low

   modport src
   (
      output buttonInN,
      output sleepN
   );
   modport dst
   (
      input buttonInN,
      input sleepN
   );
endinterface : pbr_sync_if

/* File: rtl/pbr_input_sync.sv */
// Three-stage synchroniser with agreement filter for the button and sleep state pins
`timescale 1ns/10ps
`include "pbr_cfg.svh"
module pbr_input_sync
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [1:0] rawInN,
   pbr_sync_if.src         syncOut
);

   logic [1:0] stage1_q;   // Metastability catcher, read only by stage 2
   logic [1:0] stage2_q;
   logic [1:0] stage3_q;
   logic [1:0] level_q;    // Accepted level
   logic [1:0] level_d;

   // A change counts only once stages 2 and 3 agree, so a one-cycle glitch is dropped
   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_bit
         always_comb
         begin
            level_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : level_q[i];
         end
      end
   endgenerate

   // Register all stages; reset holds the quiet level of each pin
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         stage1_q <= `PBR_SYNC_RESET;
         stage2_q <= `PBR_SYNC_RESET;
         stage3_q <= `PBR_SYNC_RESET;
         level_q  <= `PBR_SYNC_RESET;
      end
      else
      begin
         stage1_q <= rawInN;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         level_q  <= level_d;
      end
   end

   assign syncOut.buttonInN = level_q[0];
   assign syncOut.sleepN    = level_q[1];

endmodule : pbr_input_sync

/* File: testbench/pbr_chipset_model.sv */
// Behavioural chipset model: wakes or sleeps the supply on each power-button press
`timescale 1ns/10ps
module pbr_chipset_model
#(
   parameter bit AFTER_OUTAGE = 1'b1   // After-outage control bit, must be one
)
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic powerButtonOutputN,
   output logic      sleepStateN
);
   logic lastButtonN;   // Button level seen on the previous edge

   // Toggle the sleep state on each falling edge of the button line
   // A power loss takes the chipset down as well, so it restarts asleep
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sleepStateN <= 1'b0;
         lastButtonN <= 1'b1;
      end
      else
      begin
         lastButtonN <= powerButtonOutputN;
         if (AFTER_OUTAGE && lastButtonN && !powerButtonOutputN)
            sleepStateN <= !sleepStateN;
      end
   end
endmodule : pbr_chipset_model

/* File: testbench/tb_pbr_recovery_top.sv */
// Self-checking bench of the power recovery block
`timescale 1ns/10ps
`include "pbr_cfg.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin badCount++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_pbr_recovery_top;
   localparam int PULSE = 20;   // Short pulse keeps the run brief
   logic clk = 1'b0, sys_rst = 1'b1;
   logic btnN = 1'b1, kbdN = 1'b1, pbOutN, supN, sleepN, keptSup, retSup = 1'b0;
   logic [1:0] retPol = 2'h0, keptPol;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   int badCount = 0, checks = 0;

   always #5 clk = !clk;

   pbr_recovery_top #(.PULSE_CYCLES(PULSE)) u_pbr_recovery_top
   (
      .clk(clk), .sys_rst(sys_rst), .powerButtonInputN(btnN), .sleepStateN(sleepN),
      .keyboardPowerRequestN(kbdN), .powerButtonOutputN(pbOutN), .supplyOnN(supN),
      .retainedPolicy(retPol), .retainedSupplyOn(retSup), .keptPolicy(keptPol),
      .keptSupplyOn(keptSup), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   pbr_chipset_model u_pbr_chipset_model
   (
      .clk(clk), .sys_rst(sys_rst), .powerButtonOutputN(pbOutN), .sleepStateN(sleepN)
   );

   // Prints the verdict and stops
   task automatic final_report();
      if (badCount == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report

   // Write one word; address and data offered together, each dropped once taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit awOk, wOk, awTk, wTk;
      @(posedge clk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      awOk = 0; wOk = 0;
      while (!(awOk && wOk))
      begin
         @(negedge clk);
         awTk = awvalid && awready;
         wTk = wvalid && wready;
         @(posedge clk);
         if (awTk) begin awvalid <= 1'b0; awOk = 1; end
         if (wTk) begin wvalid <= 1'b0; wOk = 1; end
      end
      do @(negedge clk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask : axi_write

   // Read one word; ready held until the answer is seen
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(negedge clk);
      d = rdata; r = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask : axi_read

   // Hold one input low for len cycles and count low cycles of the button output
   task automatic count_low(input int sel, input int len, input int win, output int c);
      c = 0;
      for (int i = 0; i < win; i++)
      begin
         @(posedge clk);
         if (sel == 1) btnN <= (i >= len);
         if (sel == 2) kbdN <= (i >= len);
         @(negedge clk);
         if (pbOutN !== 1'b1) c++;
      end
   endtask : count_low

   // Standby return under one policy and one recorded supply state
   task automatic t_recovery(input logic [1:0] p, input logic s);
      int c;
      logic e;
      @(posedge clk);
      retPol <= p; retSup <= s; sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      count_low(0, 0, 60, c);
      e = (p == 2'h1) || (p == 2'h2 && s);
      `CHK(c, (e ? PULSE : 0))
      `CHK(supN, !e)
      `CHK(keptSup, e)
      `CHK(keptPol, p)
   endtask : t_recovery

   // Front-panel button enabled, then disabled
   task automatic t_button();
      int c;
      logic [1:0] r;
      count_low(1, 30, 50, c);
      `CHK(c, 30)
      axi_write(`PBR_CTRL_OFFSET, 32'h0, r);
      count_low(1, 30, 50, c);
      `CHK(c, 0)
      axi_write(`PBR_CTRL_OFFSET, `PBR_CTRL_RESET, r);
   endtask : t_button

   // Keyboard request, then the supply follows the chipset
   task automatic t_keyboard();
      int c;
      count_low(2, 15, 40, c);
      `CHK(c, 15)
      `CHK(supN, !sleepN)
      `CHK(keptSup, sleepN)
   endtask : t_keyboard

   // Register access, unmapped place and read-only status
   task automatic t_axi();
      logic [31:0] d;
      logic [1:0] r;
      axi_write(`PBR_CTRL_OFFSET, 32'h0000_0005, r);
      `CHK(r, `PBR_RESP_OKAY)
      axi_read(`PBR_CTRL_OFFSET, d, r);
      `CHK(d, 32'h0000_0005)
      // Without strobe 0 the control byte must stay as it is
      wstrb <= 4'hE;
      axi_write(`PBR_CTRL_OFFSET, 32'h0000_0002, r);
      wstrb <= 4'hF;
      `CHK(r, `PBR_RESP_OKAY)
      axi_read(`PBR_CTRL_OFFSET, d, r);
      `CHK(d, 32'h0000_0005)
      `CHK(keptPol, 2'h1)
      axi_read(8'h10, d, r);
      `CHK(r, `PBR_RESP_SLVERR)
      `CHK(d, 32'h0)
      axi_write(`PBR_STAT_OFFSET, 32'hF, r);
      `CHK(r, `PBR_RESP_OKAY)
      axi_read(`PBR_STAT_OFFSET, d, r);
      `CHK(d[`PBR_STAT_PBOUT_BIT], 1'b1)
   endtask : t_axi

   // Main sequence
   initial
   begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      for (int p = 0; p < 4; p++)
         for (int s = 0; s < 2; s++)
            t_recovery(p[1:0], s[0]);
      t_button();
      t_keyboard();
      t_axi();
      final_report();
   end

   // Watchdog against a hung handshake
   initial
   begin
      #200000;
      badCount++;
      final_report();
   end
endmodule : tb_pbr_recovery_top
